// File: pkg/siu_pkg.sv
// store instruction unit: opcodes, extended opcodes and sizes
// assumes little-endian bit numbering of the instruction word, bit 31 = msb
package siu_pkg;
    localparam int SIU_XLEN = 32;
    localparam int SIU_FLEN = 64;
    localparam int SIU_REGS = 32;
    localparam logic [5:0] SIU_OP_X = 6'h1F;
    localparam logic [5:0] SIU_OP_STFS = 6'h34;
    localparam logic [5:0] SIU_OP_STFSU = 6'h35;
    localparam logic [5:0] SIU_OP_STFD = 6'h36;
    localparam logic [5:0] SIU_OP_STFDU = 6'h37;
    localparam logic [5:0] SIU_OP_STH = 6'h2C;
    localparam logic [5:0] SIU_OP_STHU = 6'h2D;
    localparam logic [5:0] SIU_OP_STMW = 6'h2F;
    localparam logic [9:0] SIU_XO_STFDX = 10'h2D7;
    localparam logic [9:0] SIU_XO_STFDUX = 10'h2F7;
    localparam logic [9:0] SIU_XO_STFIWX = 10'h3D7;
    localparam logic [9:0] SIU_XO_STFSX = 10'h297;
    localparam logic [9:0] SIU_XO_STFSUX = 10'h2B7;
    localparam logic [9:0] SIU_XO_STHX = 10'h197;
    localparam logic [9:0] SIU_XO_STHUX = 10'h1B7;
    localparam logic [9:0] SIU_XO_STHBRX = 10'h396;
    // byte counts of memory accesses
    localparam logic [3:0] SIU_SZ_HALF = 4'h2;
    localparam logic [3:0] SIU_SZ_WORD = 4'h4;
    localparam logic [3:0] SIU_SZ_DBL = 4'h8;
    localparam logic [4:0] SIU_REG_ZERO = 5'h00;
    localparam logic [4:0] SIU_REG_LAST = 5'h1F;
    localparam logic [31:0] SIU_WORD_STEP = 32'h0000_0004;
    localparam logic [1:0] SIU_ALIGN_OK = 2'h0;
    // single-precision conversion
    localparam int SIU_DEXP_BIAS = 1023;
    localparam int SIU_SEXP_BIAS = 127;
    localparam logic [10:0] SIU_DEXP_MAX = 11'h7FF;
    localparam logic [7:0] SIU_SEXP_MAX = 8'hFF;
    localparam logic [10:0] SIU_DEXP_LO = 11'h381;
    typedef enum logic [1:0]
    {
        SIU_IDLE_S = 2'b00,
        SIU_MULT_S = 2'b01
    } siu_state_type;
endpackage

// File: verilog/siu_sp_convert.sv
// single-precision conversion of a double-format register image
// assumes the operand is already representable in single format
`timescale 1ns/10ps
module siu_sp_convert
    import siu_pkg::*;
(
    input wire logic [63:0] i_dbl, // double-format image
    output logic [31:0] o_sgl      // single-format word
);
    logic [10:0] exp_d;
    logic [10:0] exp_s;
    always_comb
    begin
        exp_d = i_dbl[62:52];
        exp_s = exp_d - 11'(SIU_DEXP_BIAS - SIU_SEXP_BIAS);
        if (exp_d >= SIU_DEXP_LO || exp_d == SIU_DEXP_MAX)
        begin
            // normal, inf and nan: truncate fraction, rebias exponent (all ones for inf and nan)
            o_sgl = {i_dbl[63], (exp_d == SIU_DEXP_MAX) ? SIU_SEXP_MAX : exp_s[7:0],
                     i_dbl[51:29]};
        end
        else
        begin
            // zero or too small: high bits only, no denormalisation here
            o_sgl = {i_dbl[63:62], i_dbl[58:29]};
        end
    end
endmodule

// File: verilog/siu_store_unit.sv
// store instruction unit: decode, address, data format, base writeback
// assumes issue holds operands stable during a multi-word store
`timescale 1ns/10ps
module siu_store_unit
    import siu_pkg::*;
(
    input wire logic i_mclk,                  // core clock
    input wire logic i_rstn,                  // async reset, low
    input wire logic i_issue,                 // instruction valid pulse
    input wire logic [31:0] i_instr,          // instruction word
    input wire logic [31:0] i_base_register,  // base register value
    input wire logic [31:0] i_index_register, // index register value
    input wire logic [31:0] i_source_register, // source register value
    input wire logic [63:0] i_fp_source_register, // fp source value
    input wire logic i_mem_ready,             // memory accepts request
    output logic o_busy,                      // unit cannot take issue
    output logic [4:0] o_src_sel,             // source register number read
    output logic o_mem_req,                   // store request valid
    output logic [31:0] o_mem_addr,           // effective address
    output logic [63:0] o_mem_data,           // data, left justified
    output logic [3:0] o_mem_size,            // bytes to store
    output logic o_wb_en,                     // base writeback pulse
    output logic [4:0] o_wb_sel,              // writeback register
    output logic [31:0] o_wb_data,            // writeback value
    output logic o_align_err,                 // misaligned multiple, pulse
    output logic o_illegal                    // unsupported or invalid, pulse
);
    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic [5:0] opc;
    logic [9:0] xo;
    logic [4:0] f_src, f_base;
    logic is_dbl, is_sgl, is_fiw, is_half, is_hbr, is_mult, is_upd, is_idx, known;
    logic [31:0] base_val, off_val, ea;
    logic [31:0] sgl_word;
    logic [63:0] data_nxt;
    logic [3:0] size_nxt;
    siu_state_type state_r;
    logic [31:0] addr_r;
    logic [4:0] cnt_r;
    logic hold_r;
    assign opc = i_instr[31:26];
    assign f_src = i_instr[25:21];
    assign f_base = i_instr[20:16];
    assign xo = i_instr[10:1];
    always_comb
    begin
        is_dbl = 1'b0;
        is_sgl = 1'b0;
        is_fiw = 1'b0;
        is_half = 1'b0;
        is_hbr = 1'b0;
        is_mult = 1'b0;
        is_upd = 1'b0;
        is_idx = 1'b0;
        if (opc == SIU_OP_X)
        begin
            is_idx = 1'b1;
            unique case (xo)
                SIU_XO_STFDX: is_dbl = 1'b1;
                SIU_XO_STFDUX:
                begin
                    is_dbl = 1'b1;
                    is_upd = 1'b1;
                end
                SIU_XO_STFIWX: is_fiw = 1'b1;
                SIU_XO_STFSX: is_sgl = 1'b1;
                SIU_XO_STFSUX:
                begin
                    is_sgl = 1'b1;
                    is_upd = 1'b1;
                end
                SIU_XO_STHX: is_half = 1'b1;
                SIU_XO_STHUX:
                begin
                    is_half = 1'b1;
                    is_upd = 1'b1;
                end
                SIU_XO_STHBRX: is_hbr = 1'b1;
                default: is_idx = 1'b0;
            endcase
        end
        else
        begin
            unique case (opc)
                SIU_OP_STFD: is_dbl = 1'b1;
                SIU_OP_STFDU:
                begin
                    is_dbl = 1'b1;
                    is_upd = 1'b1;
                end
                SIU_OP_STFS: is_sgl = 1'b1;
                SIU_OP_STFSU:
                begin
                    is_sgl = 1'b1;
                    is_upd = 1'b1;
                end
                SIU_OP_STH: is_half = 1'b1;
                SIU_OP_STHU:
                begin
                    is_half = 1'b1;
                    is_upd = 1'b1;
                end
                SIU_OP_STMW: is_mult = 1'b1;
                default: is_mult = 1'b0;
            endcase
        end
    end
    assign known = is_dbl | is_sgl | is_fiw | is_half | is_hbr | is_mult;

    // ----------------------------------------------------------------
    // effective address
    // ----------------------------------------------------------------
    // update forms never substitute zero; base 0 there raises o_illegal instead of a store
    assign base_val = (!is_upd && f_base == SIU_REG_ZERO) ? '0
                                                          : i_base_register;
    assign off_val = is_idx ? i_index_register
                            : {{16{i_instr[15]}}, i_instr[15:0]};
    assign ea = base_val + off_val;

    // ----------------------------------------------------------------
    // data formatting
    // ----------------------------------------------------------------
    // conversion assumes software kept the value single-representable
    siu_sp_convert u_conv
    (
        .i_dbl(i_fp_source_register),
        .o_sgl(sgl_word)
    );
    always_comb
    begin
        data_nxt = '0;
        size_nxt = SIU_SZ_WORD;
        if (is_dbl)
        begin
            data_nxt = i_fp_source_register;
            size_nxt = SIU_SZ_DBL;
        end
        else if (is_fiw)
        begin
            // raw low word; single-origin values give whatever bits they hold
            data_nxt = {i_fp_source_register[31:0], 32'h0000_0000};
        end
        else if (is_sgl)
        begin
            data_nxt = {sgl_word, 32'h0000_0000};
        end
        else if (is_half)
        begin
            data_nxt = {i_source_register[15:0], 48'h0000_0000_0000};
            size_nxt = SIU_SZ_HALF;
        end
        else if (is_hbr)
        begin
            data_nxt = {i_source_register[7:0], i_source_register[15:8],
                        48'h0000_0000_0000};
            size_nxt = SIU_SZ_HALF;
        end
        else
        begin
            data_nxt = {i_source_register, 32'h0000_0000};
        end
    end

    // ----------------------------------------------------------------
    // sequencing
    // ----------------------------------------------------------------
    // a request holds until memory takes it; multiple store steps words
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_r <= SIU_IDLE_S;
            hold_r <= 1'b0;
            o_mem_req <= 1'b0;
            o_mem_addr <= '0;
            o_mem_data <= '0;
            o_mem_size <= SIU_SZ_WORD;
            o_src_sel <= SIU_REG_ZERO;
            addr_r <= '0;
            cnt_r <= SIU_REG_ZERO;
            o_align_err <= 1'b0;
            o_illegal <= 1'b0;
        end
        else
        begin
            o_align_err <= 1'b0;
            o_illegal <= 1'b0;
            if (o_mem_req && i_mem_ready)
                o_mem_req <= 1'b0;
            unique case (state_r)
                SIU_IDLE_S:
                begin
                    if (i_issue && !hold_r && !(o_mem_req && !i_mem_ready))
                    begin
                        if (!known || (is_upd && f_base == SIU_REG_ZERO))
                            o_illegal <= 1'b1;
                        else if (is_mult && ea[1:0] != SIU_ALIGN_OK)
                            o_align_err <= 1'b1;
                        else if (is_mult)
                        begin
                            // source number is steered out, data sampled next cycle
                            state_r <= SIU_MULT_S;
                            o_src_sel <= f_src;
                            cnt_r <= f_src;
                            addr_r <= ea;
                            hold_r <= 1'b1;
                        end
                        else
                        begin
                            o_mem_req <= 1'b1;
                            o_mem_addr <= ea;
                            o_mem_data <= data_nxt;
                            o_mem_size <= size_nxt;
                        end
                    end
                end
                SIU_MULT_S:
                begin
                    if (!o_mem_req || i_mem_ready)
                    begin
                        if (hold_r)
                        begin
                            o_mem_req <= 1'b1;
                            o_mem_addr <= addr_r;
                            o_mem_data <= {i_source_register, 32'h0000_0000};
                            o_mem_size <= SIU_SZ_WORD;
                            addr_r <= addr_r + SIU_WORD_STEP;
                            hold_r <= 1'b0;
                        end
                        else if (cnt_r == SIU_REG_LAST)
                            state_r <= SIU_IDLE_S;
                        else
                        begin
                            cnt_r <= cnt_r + 5'h01;
                            o_src_sel <= cnt_r + 5'h01;
                            hold_r <= 1'b1;
                        end
                    end
                end
                default: state_r <= SIU_IDLE_S;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // base writeback and busy
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_wb_en <= 1'b0;
            o_wb_sel <= SIU_REG_ZERO;
            o_wb_data <= '0;
            o_busy <= 1'b0;
        end
        else
        begin
            o_wb_en <= 1'b0;
            if (state_r == SIU_IDLE_S && i_issue && !hold_r && !(o_mem_req && !i_mem_ready)
                && known && is_upd && f_base != SIU_REG_ZERO)
            begin
                o_wb_en <= 1'b1;
                o_wb_sel <= f_base;
                o_wb_data <= ea;
            end
            o_busy <= (state_r == SIU_MULT_S && !(cnt_r == SIU_REG_LAST && !hold_r))
                      || (i_issue && is_mult && state_r == SIU_IDLE_S && ea[1:0] == SIU_ALIGN_OK)
                      || (o_mem_req && !i_mem_ready);
        end
    end
endmodule

// File: tb/siu_mem_model.sv
// data memory stand-in: takes store requests, may stall, logs each accepted one
// assumes a request holds until it is accepted at a rising edge
`timescale 1ns/10ps
module siu_mem_model
(
    input wire logic i_mclk,        // core clock
    input wire logic i_slow,        // random stall mode
    input wire logic i_req,         // store request
    input wire logic [31:0] i_addr, // address
    input wire logic [63:0] i_data, // data, left justified
    input wire logic [3:0] i_size,  // byte count
    output logic o_ready            // accept
);
    logic [31:0] q_addr [$];
    logic [63:0] q_data [$];
    logic [3:0] q_size [$];
    int seed = 67188;
    initial o_ready = 1'b1;
    // ready moves off the sampling edge so the unit sees it settled
    always @(negedge i_mclk)
        o_ready <= i_slow ? 1'($random(seed)) : 1'b1;
    always @(posedge i_mclk)
    begin
        if (i_req && o_ready)
        begin
            q_addr.push_back(i_addr);
            q_data.push_back(i_data);
            q_size.push_back(i_size);
        end
    end
endmodule

// File: tb/siu_store_props.sv
// timing and format checks on the store unit ports
// assumes one clock domain and the hand-over cycle timing
`timescale 1ns/10ps
module siu_store_props
    import siu_pkg::*;
(
    input wire logic i_mclk,                      // clock
    input wire logic i_rstn,                      // reset, low
    input wire logic i_issue,                     // issue
    input wire logic [31:0] i_instr,              // instruction
    input wire logic [31:0] i_base_register,      // base
    input wire logic [31:0] i_index_register,     // index
    input wire logic [31:0] i_source_register,    // source
    input wire logic [63:0] i_fp_source_register, // fp source
    input wire logic i_mem_ready,                 // accept
    input wire logic o_busy,                      // busy
    input wire logic [4:0] o_src_sel,             // source select
    input wire logic o_mem_req,                   // request
    input wire logic [31:0] o_mem_addr,           // address
    input wire logic [63:0] o_mem_data,           // data
    input wire logic [3:0] o_mem_size,            // size
    input wire logic o_wb_en,                     // writeback
    input wire logic [31:0] o_wb_data,            // writeback value
    input wire logic o_align_err,                 // align fault
    input wire logic o_illegal                    // illegal
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    logic take;
    logic xf;
    logic [31:0] bz;
    logic [31:0] ea_d;
    logic [31:0] fp_lo;
    logic [15:0] src_sw;
    assign take = i_issue && !o_busy && !(o_mem_req && !i_mem_ready);
    assign xf = i_instr[31:26] == SIU_OP_X;
    assign bz = (i_instr[20:16] == SIU_REG_ZERO) ? 32'h0 : i_base_register;
    assign ea_d = bz + {{16{i_instr[15]}}, i_instr[15:0]};
    assign fp_lo = i_fp_source_register[31:0];
    assign src_sw = {i_source_register[7:0], i_source_register[15:8]};
    property p_hold;
        o_mem_req && !i_mem_ready |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_data);
    endproperty
    a_hold: assert property (p_hold) else $error("request moved before accept");
    property p_dbl;
        take && xf && i_instr[10:1] == SIU_XO_STFDX |=> o_mem_size == SIU_SZ_DBL
            && o_mem_data == $past(i_fp_source_register)
            && o_mem_addr == $past(bz) + $past(i_index_register);
    endproperty
    a_dbl: assert property (p_dbl) else $error("indexed double wrong");
    property p_iw;
        take && xf && i_instr[10:1] == SIU_XO_STFIWX |=> o_mem_data[63:32] == $past(fp_lo);
    endproperty
    a_iw: assert property (p_iw) else $error("integer word wrong");
    property p_half;
        take && i_instr[31:26] == SIU_OP_STH |=> o_mem_size == SIU_SZ_HALF
            && o_mem_data[63:48] == $past(i_source_register[15:0]) && o_mem_addr == $past(ea_d);
    endproperty
    a_half: assert property (p_half) else $error("halfword wrong");
    property p_brev;
        take && xf && i_instr[10:1] == SIU_XO_STHBRX |=> o_mem_data[63:48] == $past(src_sw);
    endproperty
    a_brev: assert property (p_brev) else $error("reversed halfword wrong");
    property p_wb;
        o_wb_en |-> o_mem_req && o_wb_data == o_mem_addr ##1 !o_wb_en;
    endproperty
    a_wb: assert property (p_wb) else $error("writeback wrong");
    property p_ill;
        take && i_instr[31:26] == SIU_OP_STHU && i_instr[20:16] == SIU_REG_ZERO
            |=> o_illegal && !o_mem_req && !o_wb_en;
    endproperty
    a_ill: assert property (p_ill) else $error("invalid update stored");
    property p_mult;
        take && i_instr[31:26] == SIU_OP_STMW && ea_d[1:0] == SIU_ALIGN_OK
            |=> o_busy && o_src_sel == $past(i_instr[25:21]) ##1 o_mem_req
            && o_mem_addr == $past(ea_d, 2);
    endproperty
    a_mult: assert property (p_mult) else $error("multiple start wrong");
    property p_align;
        take && i_instr[31:26] == SIU_OP_STMW && ea_d[1:0] != SIU_ALIGN_OK
            |=> o_align_err && !o_mem_req;
    endproperty
    a_align: assert property (p_align) else $error("misaligned multiple");
    c_stall: cover property (o_mem_req && !i_mem_ready);
    c_wb: cover property (o_wb_en);
    c_last: cover property (o_mem_req && o_busy && o_src_sel == SIU_REG_LAST);
endmodule
bind siu_store_unit siu_store_props u_props (.*);

// File: tb/tb_top.sv
// self-checking bench for the store unit with a stalling memory
// assumes siu_pkg, the memory model and the checker are compiled first
`timescale 1ns/10ps
`define CHK(n, e, g) chk(n, 64'(e), 64'(g))
module tb_top
    import siu_pkg::*;
;
    logic i_mclk = 0;
    logic i_rstn = 0;
    logic i_issue = 0;
    logic slow = 0;
    logic [31:0] i_instr = 0;
    logic [31:0] i_base_register = 0;
    logic [31:0] i_index_register = 0;
    logic [31:0] src = 0;
    logic [63:0] i_fp_source_register = 0;
    logic i_mem_ready, o_busy, o_mem_req, o_wb_en, o_align_err, o_illegal;
    logic [4:0] o_src_sel, o_wb_sel;
    logic [31:0] i_source_register, o_mem_addr, o_wb_data;
    logic [63:0] o_mem_data;
    logic [3:0] o_mem_size;
    logic [36:0] wb_last;
    int failures = 0, check_count = 0, cycles = 0, seed = 67188, wbs = 0, ills = 0, als = 0;
    logic [15:0] kinds [15] = '{{SIU_OP_STFS, 10'h0}, {SIU_OP_STFSU, 10'h0},
        {SIU_OP_STFD, 10'h0}, {SIU_OP_STFDU, 10'h0}, {SIU_OP_STH, 10'h0},
        {SIU_OP_STHU, 10'h0}, {SIU_OP_STMW, 10'h0}, {SIU_OP_X, SIU_XO_STFDX},
        {SIU_OP_X, SIU_XO_STFDUX}, {SIU_OP_X, SIU_XO_STFIWX}, {SIU_OP_X, SIU_XO_STFSX},
        {SIU_OP_X, SIU_XO_STFSUX}, {SIU_OP_X, SIU_XO_STHX}, {SIU_OP_X, SIU_XO_STHUX},
        {SIU_OP_X, SIU_XO_STHBRX}};
    // ---------------------------------------------------------------
    // register file stand-in and reference functions
    // ---------------------------------------------------------------
    function automatic logic [31:0] rf(input logic [4:0] n);
        return {27'h2D5A5A5, n};
    endfunction
    assign i_source_register = o_busy ? rf(o_src_sel) : src;
    function automatic logic upd(input logic [31:0] ins);
        return ins[31:26] inside {SIU_OP_STFSU, SIU_OP_STFDU, SIU_OP_STHU} ||
            (ins[31:26] == SIU_OP_X && ins[10:1] inside {SIU_XO_STFDUX, SIU_XO_STFSUX,
            SIU_XO_STHUX});
    endfunction
    function automatic logic [31:0] ea(input logic [31:0] ins, b, x);
        logic [31:0] bb;
        bb = (ins[20:16] == 5'h00 && !upd(ins)) ? 32'h0 : b;
        return bb + ((ins[31:26] == SIU_OP_X) ? x : {{16{ins[15]}}, ins[15:0]});
    endfunction
    function automatic logic [67:0] fmt(input logic [31:0] ins, s, input logic [63:0] f);
        logic [15:0] k;
        logic [10:0] e;
        k = {ins[31:26], ins[31:26] == SIU_OP_X ? ins[10:1] : 10'h0};
        e = f[62:52] - 11'h380;
        case (k)
            {SIU_OP_STFD, 10'h0}, {SIU_OP_STFDU, 10'h0}, {SIU_OP_X, SIU_XO_STFDX},
            {SIU_OP_X, SIU_XO_STFDUX}: return {SIU_SZ_DBL, f};
            {SIU_OP_X, SIU_XO_STFIWX}: return {SIU_SZ_WORD, f[31:0], 32'h0};
            {SIU_OP_X, SIU_XO_STHBRX}: return {SIU_SZ_HALF, s[7:0], s[15:8], 48'h0};
            {SIU_OP_STH, 10'h0}, {SIU_OP_STHU, 10'h0}, {SIU_OP_X, SIU_XO_STHX},
            {SIU_OP_X, SIU_XO_STHUX}: return {SIU_SZ_HALF, s[15:0], 48'h0};
            default: return (f[62:52] == 11'h000) ? {SIU_SZ_WORD, f[63], 63'h0}
                : {SIU_SZ_WORD, f[63], e[7:0], f[51:29], 32'h0};
        endcase
    endfunction
    task automatic chk(input string n, input logic [63:0] e, g);
        check_count++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic op_run(input logic [15:0] k, input int it);
        logic [31:0] ins, e, r;
        logic [67:0] x;
        logic [4:0] s, a;
        logic [7:0] e8;
        logic mw, bad, mis;
        int nst, w0, i0, a0, sh;
        r = $random(seed);
        s = r[12:8];
        a = (it == 0) ? 5'h00 : r[20:16];
        e8 = (r[7:0] == 8'h00 || r[7:0] == 8'hFF) ? 8'h7F : r[7:0];
        mw = k[15:10] == SIU_OP_STMW;
        i_base_register = $random(seed) & (mw ? 32'hFFFF_FFFC : 32'hFFFF_FFFF);
        i_index_register = $random(seed);
        src = $random(seed);
        i_fp_source_register = {r[31], 11'h380 + {3'h0, e8}, r[30:8], 29'h0};
        // corner case: signed zero takes the small-value path of the conversion
        if (it == 3)
            i_fp_source_register = {r[31], 63'h0};
        ins = (k[15:10] == SIU_OP_X) ? {k[15:10], s, a, r[4:0], k[9:0], 1'b0}
            : {k[15:10], s, a, r[15:2], (mw && it == 1) ? 2'h2 : 2'h0};
        slow = r[1];
        e = ea(ins, i_base_register, i_index_register);
        bad = upd(ins) && a == 5'h00;
        mis = mw && e[1:0] != 2'h0;
        nst = (bad || mis) ? 0 : (mw ? 32 - s : 1);
        w0 = wbs;
        i0 = ills;
        a0 = als;
        i_instr = ins;
        i_issue = 1'b1;
        @(negedge i_mclk);
        i_issue = 1'b0;
        for (int n = 0; n < 400; n++)
        begin
            @(negedge i_mclk);
            if (!o_busy && !o_mem_req && tb_top.mem.q_addr.size() == nst)
                break;
        end
        `CHK("idle", 1'b0, o_busy | o_mem_req);
        `CHK("illegal", bad, ills - i0);
        `CHK("align", mis, als - a0);
        `CHK("wb count", upd(ins) && !bad, wbs - w0);
        if (upd(ins) && !bad)
            `CHK("wb", {a, e}, wb_last);
        `CHK("stores", nst, mem.q_addr.size());
        for (int j = 0; j < nst && j < mem.q_addr.size(); j++)
        begin
            x = mw ? {SIU_SZ_WORD, rf(5'(s + j)), 32'h0} : fmt(ins, src, i_fp_source_register);
            `CHK("addr", 32'(e + 4 * j), mem.q_addr[j]);
            `CHK("size", x[67:64], mem.q_size[j]);
            sh = 64 - 8 * x[67:64];
            `CHK("data", x[63:0] >> sh, mem.q_data[j] >> sh);
        end
        mem.q_addr.delete();
        mem.q_data.delete();
        mem.q_size.delete();
    endtask
    siu_store_unit dut (.*);
    siu_mem_model mem (.i_mclk(i_mclk), .i_slow(slow), .i_req(o_mem_req), .i_addr(o_mem_addr),
        .i_data(o_mem_data), .i_size(o_mem_size), .o_ready(i_mem_ready));
    initial
    begin
        forever #5 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk)
    begin
        cycles++;
        wbs += (o_wb_en === 1'b1);
        ills += (o_illegal === 1'b1);
        als += (o_align_err === 1'b1);
        if (o_wb_en === 1'b1)
            wb_last = {o_wb_sel, o_wb_data};
        if (cycles > 30000)
        begin
            failures++;
            complete_run();
        end
    end
    initial
    begin
        repeat (10) @(negedge i_mclk);
        i_rstn = 1'b1;
        for (int it = 0; it < 4; it++)
            foreach (kinds[q])
                op_run(kinds[q], it);
        complete_run();
    end
endmodule
